// ===== logic/osd_overlay.sv
// Overlay stage: line-block interrupts, two cursor fonts, window and
// blank gating, raster colour and scan-line doubling.
// Assumes sync and blanking pins are asynchronous; block and character
// inputs come from logic on CLK_I.
`timescale 1ns/10ps
`default_nettype none
module osd_overlay
    import osd_pkg::*;
(
    input  wire logic                          CLK_I,
    input  wire logic                          RST_I,
    input  wire logic                          HSYNC_I,
    input  wire logic                          VSYNC_I,
    input  wire logic                          HBLANK_I,
    input  wire logic                          VBLANK_I,
    input  wire logic [7:0]                    CTRL1_I,
    input  wire logic [7:0]                    CTRL2_I,
    input  wire logic [7:0]                    CTRL3_I,
    input  wire logic [osd_pkg::RAST_W-1:0]    RASTER_I,
    input  wire logic [osd_pkg::EDGE_W-1:0]    TOP_EDGE_REG_I,
    input  wire logic [osd_pkg::EDGE_W-1:0]    BOTTOM_EDGE_REG_I,
    input  wire logic [osd_pkg::EDGE_W-1:0]    LEFT_EDGE_REG_I,
    input  wire logic [osd_pkg::EDGE_W-1:0]    RIGHT_EDGE_REG_I,
    input  wire logic [osd_pkg::HPOS_W-1:0]    CURSOR_HPOS_I,
    input  wire logic [1:0][osd_pkg::VPOS_W-1:0] CURSOR_VPOS_I,
    input  wire logic [1:0]                    CURSOR_EN_I,
    input  wire logic [1:0][osd_pkg::PLANES-1:0] PLANE_SEL_I,
    input  wire logic                          FONT_WE_I,
    input  wire logic [osd_pkg::RAM_AW-1:0]    FONT_WADDR_I,
    input  wire logic [osd_pkg::PLANES-1:0]    FONT_WDATA_I,
    input  wire logic [1:0]                    BLK_ACT_I,
    input  wire logic [1:0]                    BLK_SHOWN_I,
    input  wire logic [2:0]                    MODE_I,
    input  wire logic                          CHAR_VALID_I,
    input  wire logic [3:0]                    CHAR_PAL_I,
    input  wire logic                          CHAR_BLANKING_OUT_I,
    input  wire logic                          CHAR_AUXILIARY_OUT_I,
    input  wire logic                          LB_ACK_I,
    input  wire logic                          CF_ACK_I,
    output logic                               LINE_BLOCK_IRQ_O,
    output logic                               CURSOR_FONT_IRQ_O,
    output logic [osd_pkg::RAST_W-1:0]         PIX_O,
    output osd_pkg::pix_kind_e                 PIX_KIND_O,
    output logic                               BLANKING_OUT_O,
    output logic                               AUXILIARY_OUT_O
);
    import osd_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0]                 s1;        // Pin sync, first stage.
        logic [3:0]                 s2;        // Pin sync, second stage.
        logic                       hs_prev;
        logic [HCNT_W-1:0]          hcnt;
        logic [LINE_W-1:0]          line;
        logic [1:0]                 blk_prev;
        logic [1:0]                 vact;
        logic [1:0]                 sub;
        logic [1:0][ROW_W-1:0]      row;
        logic [1:0]                 hit;
        logic                       pri1;
        logic                       cv;
        logic [3:0]                 cpal;
        logic                       co1;
        logic                       co2;
        logic                       mchar;
        logic                       maux;
        logic                       barea;
        logic [RAST_W-1:0]          rast;
        logic                       lb_irq;
        logic                       cf_irq;
        logic [RAST_W-1:0]          pix;
        pix_kind_e                  kind;
        logic                       blank;
        logic                       aux;
    } st_s;

    st_s                          cur_q;
    st_s                          nxt_d;
    logic [1:0][RAM_AW-1:0]       ram_addr;
    logic [1:0][PLANES-1:0]       ram_data;
    logic [1:0][PLANES-1:0]       pal;
    logic [1:0]                   vis;
    logic [1:0][LINE_W-1:0]       vstart;
    logic [HCNT_W-1:0]            hstart;
    logic [HCNT_W-1:0]            dotoff;
    logic [LINE_W-1:0]            line_nx;
    logic [1:0]                   elig;
    logic                         hs_rise;
    logic                         biscan;
    logic                         lb_evt;
    logic                         cf_evt;
    logic                         vin;
    logic                         hin;
    logic                         vwin;
    logic                         vblk;
    logic                         hwin;
    logic                         hblk;
    logic                         outside;
    logic                         char_on;

    // ----------------------------------------------------------------
    // Cursor font store
    // ----------------------------------------------------------------
    cursor_font_ram u_ram (
        .clk_i   (CLK_I),
        .we_i    (FONT_WE_I),
        .waddr_i (FONT_WADDR_I),
        .wdata_i (FONT_WDATA_I),
        .raddr_i (ram_addr),
        .rdata_o (ram_data)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Pipeline: cycle 0 addresses the font store and samples the
    // character side, cycle 1 merges both into the output registers.
    always_comb begin
        nxt_d   = cur_q;
        lb_evt  = 1'b0;
        cf_evt  = 1'b0;
        vis     = 2'b00;
        pal     = '0;
        char_on = 1'b0;
        biscan  = CTRL1_I[C1_BISCAN];

        // Pins pass two flops; only the second stage is read below.
        nxt_d.s1      = {VBLANK_I, HBLANK_I, VSYNC_I, HSYNC_I};
        nxt_d.s2      = cur_q.s1;
        nxt_d.hs_prev = cur_q.s2[PIN_HS];
        hs_rise       = cur_q.s2[PIN_HS] & ~cur_q.hs_prev;
        line_nx = cur_q.s2[PIN_VS] ? '0 : cur_q.line + 11'h001;
        nxt_d.hcnt = hs_rise ? '0 : cur_q.hcnt + 12'h001;

        // Line-block activity is judged once per line; a block set off
        // display is never eligible, and the window does not enter.
        elig = BLK_ACT_I & BLK_SHOWN_I;
        if (hs_rise) begin
            nxt_d.line     = line_nx;
            nxt_d.blk_prev = elig;
            // Overlapping blocks keep activity high, so one end only.
            lb_evt = CTRL2_I[C2_IRQ_L2] ? (cur_q.blk_prev[1] & ~elig[1])
                                        : (cur_q.blk_prev[0] & ~elig[0]);
        end

        // Cursor horizontal start in units of two oscillator periods.
        hstart = {CURSOR_HPOS_I, 1'b0};
        dotoff = cur_q.hcnt - hstart;
        for (int i = 0; i < 2; i++) begin
            vstart[i] = biscan ? {CURSOR_VPOS_I[i], 1'b0}
                               : {1'b0, CURSOR_VPOS_I[i]};
            if (hs_rise) begin
                if (CURSOR_EN_I[i] && line_nx == vstart[i]) begin
                    nxt_d.vact[i] = 1'b1;
                    nxt_d.row[i]  = '0;
                    nxt_d.sub[i]  = 1'b0;
                end else if (cur_q.vact[i]) begin
                    if (biscan && !cur_q.sub[i]) begin
                        nxt_d.sub[i] = 1'b1;
                    end else begin
                        nxt_d.sub[i] = 1'b0;
                        if (cur_q.row[i] == LAST_ROW) begin
                            nxt_d.vact[i] = 1'b0;
                            cf_evt = 1'b1;
                        end else begin
                            nxt_d.row[i] = cur_q.row[i] + 5'h01;
                        end
                    end
                end
            end
            nxt_d.hit[i] = cur_q.vact[i] && cur_q.hcnt >= hstart
                           && dotoff < FONT_W_CNT;
            ram_addr[i] = {i[0], cur_q.row[i], dotoff[DOT_W-1:0]};
            pal[i] = ram_data[i] & PLANE_SEL_I[i];
            vis[i] = cur_q.hit[i] & (pal[i] != '0);
        end
        nxt_d.pri1 = CURSOR_VPOS_I[0] >= CURSOR_VPOS_I[1];

        // Window and blank borders; vertical in lines, horizontal in
        // four-period units. Each function picks window or blank.
        vin  = cur_q.line >= {1'b0, TOP_EDGE_REG_I}
               && cur_q.line < {1'b0, BOTTOM_EDGE_REG_I};
        hin  = cur_q.hcnt[HCNT_W-1:EDGE_SHIFT] >= LEFT_EDGE_REG_I
               && cur_q.hcnt[HCNT_W-1:EDGE_SHIFT] < RIGHT_EDGE_REG_I;
        vwin = CTRL1_I[C1_VFUNC_EN] & ~CTRL2_I[C2_VBLANK];
        vblk = CTRL1_I[C1_VFUNC_EN] & CTRL2_I[C2_VBLANK];
        hwin = CTRL2_I[C2_HFUNC_EN] & ~CTRL2_I[C2_HBLANK];
        hblk = CTRL2_I[C2_HFUNC_EN] & CTRL2_I[C2_HBLANK];
        outside = (vwin & ~vin) | (hwin & ~hin);
        nxt_d.mchar = outside
                      & |(CTRL3_I[C3_MODE_MSB:C3_MODE_LSB] & MODE_I);
        nxt_d.maux  = outside;
        nxt_d.barea = ((vblk & ~vin) | (hblk & ~hin))
                      & ~cur_q.s2[PIN_HBL] & ~cur_q.s2[PIN_VBL];
        nxt_d.cv   = CHAR_VALID_I;
        nxt_d.cpal = CHAR_PAL_I;
        nxt_d.co1  = CHAR_BLANKING_OUT_I;
        nxt_d.co2  = CHAR_AUXILIARY_OUT_I;
        nxt_d.rast = RASTER_I;

        // Output merge: cursor over character over raster. The cursor
        // is not windowed and never drives the auxiliary output.
        char_on = cur_q.cv & ~cur_q.mchar;
        nxt_d.aux = cur_q.co2 & ~cur_q.maux;
        nxt_d.blank = cur_q.barea | (char_on & cur_q.co1);
        if (vis[0] && (cur_q.pri1 || !vis[1])) begin
            nxt_d.kind = PK_CURSOR;
            nxt_d.pix  = {3'h0, pal[0]};
        end else if (vis[1]) begin
            nxt_d.kind = PK_CURSOR;
            nxt_d.pix  = {3'h0, pal[1]};
        end else if (char_on) begin
            nxt_d.kind = PK_CHAR;
            nxt_d.pix  = {3'h0, cur_q.cpal};
        end else if (!cur_q.barea) begin
            // Raster fills all that is left, outside any blank area.
            nxt_d.kind  = PK_RASTER;
            nxt_d.pix   = cur_q.rast;
            nxt_d.blank = cur_q.rast[RAST_BLANKING_OUT];
            nxt_d.aux   = nxt_d.aux | cur_q.rast[RAST_AUXILIARY_OUT];
        end else begin
            nxt_d.kind = PK_NONE;
            nxt_d.pix  = '0;
        end

        // Pending flags: a new event in the acknowledge cycle wins.
        nxt_d.lb_irq = lb_evt | (cur_q.lb_irq & ~LB_ACK_I);
        nxt_d.cf_irq = cf_evt | (cur_q.cf_irq & ~CF_ACK_I);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // The whole state is cleared together so outputs are quiet at reset.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            cur_q <= '0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    // Outputs come straight from the state register.
    assign LINE_BLOCK_IRQ_O  = cur_q.lb_irq;
    assign CURSOR_FONT_IRQ_O = cur_q.cf_irq;
    assign PIX_O             = cur_q.pix;
    assign PIX_KIND_O        = cur_q.kind;
    assign BLANKING_OUT_O    = cur_q.blank;
    assign AUXILIARY_OUT_O   = cur_q.aux;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    sequence lb_end_s;
        hs_rise && cur_q.blk_prev[1] && !elig[1] && CTRL2_I[C2_IRQ_L2];
    endsequence

    // A restart on the same line would hide the completion, so the
    // last row is only judged when no new start is due.
    sequence row_last_s;
        hs_rise && cur_q.vact[0] && cur_q.row[0] == LAST_ROW
        && (!biscan || cur_q.sub[0])
        && !(CURSOR_EN_I[0] && line_nx == vstart[0]);
    endsequence

    // First line of a doubled row: the row number must wait a line.
    sequence half_row_s;
        hs_rise && cur_q.vact[0] && biscan && !cur_q.sub[0]
        && !(CURSOR_EN_I[0] && line_nx == vstart[0]);
    endsequence

    // Line-block request checks.
    lb_raise_a: assert property (lb_evt |=> LINE_BLOCK_IRQ_O)
        else $error("line block end did not raise request");
    lb_layer_a: assert property (lb_end_s |=> LINE_BLOCK_IRQ_O)
        else $error("layer 2 block end missed");
    lb_cause_a: assert property ($rose(LINE_BLOCK_IRQ_O)
        |-> $past(hs_rise) && $past(cur_q.blk_prev != 2'b00))
        else $error("block request without a displayed block");
    lb_hold_a: assert property (LINE_BLOCK_IRQ_O && !LB_ACK_I
        |=> LINE_BLOCK_IRQ_O)
        else $error("pending block request dropped");
    lb_clear_a: assert property (LINE_BLOCK_IRQ_O && LB_ACK_I
        && !lb_evt |=> !LINE_BLOCK_IRQ_O)
        else $error("acknowledged block request stayed pending");

    // Cursor font checks.
    cf_done_a: assert property (row_last_s
        |=> CURSOR_FONT_IRQ_O ##0 !cur_q.vact[0])
        else $error("cursor completion not flagged");
    cf_hold_a: assert property (CURSOR_FONT_IRQ_O && !CF_ACK_I
        |=> CURSOR_FONT_IRQ_O)
        else $error("pending cursor request dropped");
    dbl_row_a: assert property (half_row_s
        |=> cur_q.sub[0] && $stable(cur_q.row[0]))
        else $error("doubled scan advanced a cursor row early");
    cursor_win_a: assert property (vis[0]
        |=> PIX_KIND_O == PK_CURSOR
        && AUXILIARY_OUT_O == $past(cur_q.co2 & ~cur_q.maux))
        else $error("cursor hidden or auxiliary masked");
    cursor_aux_a: assert property (vis != 2'b00 && !cur_q.co2
        |=> !AUXILIARY_OUT_O)
        else $error("cursor drove the auxiliary output");
    tie_font1_a: assert property (vis == 2'b11 && cur_q.pri1
        |=> PIX_O == $past({3'h0, pal[0]}))
        else $error("overlap picked wrong cursor font");

    // Blank area and raster checks.
    blank_gap_a: assert property (cur_q.barea
        |-> !$past(cur_q.s2[PIN_HBL]) && !$past(cur_q.s2[PIN_VBL]))
        else $error("blank area in blanking interval");
    blank_raster_a: assert property (cur_q.barea
        |=> BLANKING_OUT_O && PIX_KIND_O != PK_RASTER)
        else $error("blank area shows raster or no blanking");
    char_raster_a: assert property (char_on
        |=> PIX_KIND_O != PK_RASTER)
        else $error("raster colour shown over a character");

endmodule
`default_nettype wire

// ===== logic/osd_pkg.sv
// Shared constants of the on-screen-display overlay block.
// Assumes one CLK_I period equals one display oscillator period.
package osd_pkg;

    // ----------------------------------------------------------------
    // Geometry and widths
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ   = 100;
    localparam int unsigned FONTS     = 2;
    localparam int unsigned FONT_W    = 32;   // Dots per cursor row.
    localparam int unsigned PLANES    = 4;    // Bits of data per dot.
    localparam int unsigned HPOS_W    = 11;   // 2048 steps.
    localparam int unsigned VPOS_W    = 10;   // 1024 steps.
    localparam int unsigned HCNT_W    = 12;   // Oscillator periods.
    localparam int unsigned LINE_W    = 11;   // Lines, room for doubling.
    localparam int unsigned EDGE_W    = 10;   // Border register width.
    localparam int unsigned ROW_W     = 5;
    localparam int unsigned DOT_W     = 5;
    localparam int unsigned RAM_AW    = 1 + ROW_W + DOT_W;
    localparam int unsigned RAST_W    = 7;
    localparam logic [ROW_W-1:0] LAST_ROW = 5'h13;  // 20 rows.
    localparam logic [HCNT_W-1:0] FONT_W_CNT = 12'h020;

    // ----------------------------------------------------------------
    // Control register bit positions
    // ----------------------------------------------------------------
    localparam int unsigned C1_DISP_EN   = 0;
    localparam int unsigned C1_BISCAN    = 1;
    localparam int unsigned C1_VFUNC_EN  = 5;
    localparam int unsigned C2_HFUNC_EN  = 4;
    localparam int unsigned C2_HBLANK    = 5;
    localparam int unsigned C2_VBLANK    = 6;
    localparam int unsigned C2_IRQ_L2    = 7;
    localparam int unsigned C3_MODE_LSB  = 5;
    localparam int unsigned C3_MODE_MSB  = 7;
    localparam int unsigned RAST_BLANKING_OUT    = 5;
    localparam int unsigned RAST_AUXILIARY_OUT    = 6;

    // ----------------------------------------------------------------
    // Unit shifts and pin sync vector layout
    // ----------------------------------------------------------------
    localparam int unsigned HPOS_SHIFT = 1;   // 2 oscillator periods.
    localparam int unsigned EDGE_SHIFT = 2;   // 4 oscillator periods.
    localparam int unsigned PIN_HS  = 0;
    localparam int unsigned PIN_VS  = 1;
    localparam int unsigned PIN_HBL = 2;
    localparam int unsigned PIN_VBL = 3;

    typedef enum logic [1:0] {
        PK_NONE   = 2'h0,
        PK_RASTER = 2'h1,
        PK_CHAR   = 2'h2,
        PK_CURSOR = 2'h3
    } pix_kind_e;

endpackage

// ===== logic/cursor_font_ram.sv
// Dot store for the two cursor fonts, one write and two read ports.
// Assumes a single clock; read data appear one edge after the address.
`timescale 1ns/10ps
`default_nettype none
module cursor_font_ram
    import osd_pkg::*;
(
    input  wire logic                         clk_i,
    input  wire logic                         we_i,
    input  wire logic [osd_pkg::RAM_AW-1:0]   waddr_i,
    input  wire logic [osd_pkg::PLANES-1:0]   wdata_i,
    input  wire logic [1:0][osd_pkg::RAM_AW-1:0] raddr_i,
    output logic      [1:0][osd_pkg::PLANES-1:0] rdata_o
);
    import osd_pkg::*;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // Rows 20 to 31 of each font are never addressed by the scan logic.
    logic [PLANES-1:0] mem [0:(1<<RAM_AW)-1];

    // Write port and the registered read ports.
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o[0] <= mem[raddr_i[0]];
        rdata_o[1] <= mem[raddr_i[1]];
    end

endmodule
`default_nettype wire

// ===== tb/video_timing_model.sv
// Video timing source standing in for the display path beyond the pins.
// Assumes one clock per oscillator period and a short test frame.
`timescale 1ns/10ps
`default_nettype none
module video_timing_model #(
    parameter int LINE_CLKS   = 96,
    parameter int FRAME_LINES = 56
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      hsync_o,
    output logic      vsync_o,
    output logic      hblank_o,
    output logic      vblank_o
);
    logic [7:0] col_q;
    logic [7:0] line_q;

    // Column and line counters; the frame is short to keep runs brief.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            col_q  <= 8'h00;
            line_q <= 8'h00;
        end else if (col_q == 8'(LINE_CLKS - 1)) begin
            col_q  <= 8'h00;
            line_q <= (line_q == 8'(FRAME_LINES - 1)) ? 8'h00 : line_q + 8'h01;
        end else begin
            col_q <= col_q + 8'h01;
        end
    end

    // Sync and blanking levels; vsync spans two line starts.
    assign hsync_o  = (col_q < 8'h08);
    assign hblank_o = (col_q < 8'h10);
    assign vsync_o  = (line_q < 8'h02);
    assign vblank_o = (line_q < 8'h03);
endmodule
`default_nettype wire

// ===== tb/osd_overlay_tb.sv
// Self-checking bench for the overlay stage.
// Assumes the timing model drives the sync and blanking pins.
`timescale 1ns/10ps
`default_nettype none
module osd_overlay_tb;
    import osd_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic             clk = 1'b0, rst = 1'b1, meas = 1'b0;
    logic             hs, vs, hb, vb, lbi, cfi, blo, axo;
    logic             fwe = 1'b0, lack = 1'b0, cack = 1'b0;
    logic             cval = 1'b0, co1 = 1'b0, co2 = 1'b0;
    logic [7:0]       c1 = 8'h00, c2 = 8'h00, c3 = 8'h00;
    logic [6:0]       rast = 7'h1f;
    logic [6:0]       pix;
    logic [9:0]       top = 10'h000, bot = 10'h3ff;
    logic [9:0]       lft = 10'h002, rgt = 10'h004;
    logic [10:0]      hpos = 11'h014, fwa = 11'h000;
    logic [1:0][9:0]  vpos = {10'h004, 10'h004};
    logic [1:0]       cen = 2'h0, bact = 2'h0, bshown = 2'h0;
    logic [1:0][3:0]  psel = {4'hf, 4'hf};
    logic [3:0]       fwd = 4'h0, cpal = 4'h3, ecol = 4'h0;
    logic [2:0]       mode = 3'h1;
    pix_kind_e        kind;
    int               fails = 0, check_count = 0, cnt [7];
    // Row fields: sel, window, act[1:0], shown[1:0], expected request.
    logic [6:0]       rows [6] = '{7'h0b, 7'h14, 7'h55, 7'h4a, 7'h08, 7'h2b};

    // ------------------------------------------------------------
    // Design and partner
    // ------------------------------------------------------------
    always #5 clk = ~clk;
    video_timing_model tim (.clk_i(clk), .rst_i(rst), .hsync_o(hs),
        .vsync_o(vs), .hblank_o(hb), .vblank_o(vb));
    osd_overlay dut (.CLK_I(clk), .RST_I(rst), .HSYNC_I(hs), .VSYNC_I(vs),
        .HBLANK_I(hb), .VBLANK_I(vb), .CTRL1_I(c1), .CTRL2_I(c2),
        .CTRL3_I(c3), .RASTER_I(rast), .TOP_EDGE_REG_I(top),
        .BOTTOM_EDGE_REG_I(bot), .LEFT_EDGE_REG_I(lft),
        .RIGHT_EDGE_REG_I(rgt), .CURSOR_HPOS_I(hpos), .CURSOR_VPOS_I(vpos),
        .CURSOR_EN_I(cen), .PLANE_SEL_I(psel), .FONT_WE_I(fwe),
        .FONT_WADDR_I(fwa), .FONT_WDATA_I(fwd), .BLK_ACT_I(bact),
        .BLK_SHOWN_I(bshown), .MODE_I(mode), .CHAR_VALID_I(cval),
        .CHAR_PAL_I(cpal), .CHAR_BLANKING_OUT_I(co1), .CHAR_AUXILIARY_OUT_I(co2),
        .LB_ACK_I(lack), .CF_ACK_I(cack), .LINE_BLOCK_IRQ_O(lbi),
        .CURSOR_FONT_IRQ_O(cfi), .PIX_O(pix), .PIX_KIND_O(kind),
        .BLANKING_OUT_O(blo), .AUXILIARY_OUT_O(axo));

    // Frame monitor on the falling edge, where outputs have settled;
    // counting whole frames keeps it blind to latency.
    always @(negedge clk) begin
        if (meas) begin
            cnt[0] += (kind === PK_CURSOR) ? 1 : 0;
            cnt[1] += (kind === PK_CURSOR && pix[3:0] === ecol) ? 1 : 0;
            cnt[2] += (kind === PK_CURSOR && axo === 1'b1) ? 1 : 0;
            cnt[3] += (kind === PK_RASTER) ? 1 : 0;
            cnt[4] += (blo === 1'b1) ? 1 : 0;
            cnt[5] += (blo === 1'b1 && kind === PK_RASTER) ? 1 : 0;
            cnt[6] += (kind === PK_RASTER && pix === rast) ? 1 : 0;
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t flag got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            fails++;
            $display("BAD t=%0t count got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Inputs change well after the design has seen the sync rise.
    task automatic next_line;
        @(posedge hs);
        tick(8);
    endtask
    task automatic pulse_ack(input logic lb);
        lack = lb;
        cack = ~lb;
        tick(1);
        lack = 1'b0;
        cack = 1'b0;
        tick(1);
    endtask
    task automatic fill(input logic f, input logic [3:0] v);
        fwe = 1'b1;
        for (int r = 0; r < 20; r++) begin
            for (int d = 0; d < 32; d++) begin
                fwa = {f, 5'(r), 5'(d)};
                fwd = v;
                tick(1);
            end
        end
        fwe = 1'b0;
    endtask
    // One full frame from mid line 0, so no region is cut at the ends.
    task automatic frame(input logic [3:0] c);
        ecol = c;
        @(posedge vs);
        tick(30);
        cnt = '{default: 0};
        meas = 1'b1;
        tick(5376);
        meas = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (90000) @(posedge clk);
        fails++;
        end_of_test();
    end
    initial begin
        tick(12);
        rst = 1'b0;
        chk_bit(lbi, 1'b0);
        chk_bit(cfi, 1'b0);
        $display("test reset done");
        tick(4);
        // Block table: one block line, then a line past it.
        for (int i = 0; i < 6; i++) begin
            c2 = {rows[i][6], 2'b00, rows[i][5], 4'h0};
            c1 = rows[i][5] ? 8'h21 : 8'h00;
            // An empty vertical window leaves the block outside it.
            bot = rows[i][5] ? 10'h000 : 10'h3ff;
            pulse_ack(1'b1);
            next_line();
            bact = rows[i][4:3];
            bshown = rows[i][2:1];
            next_line();
            bact = 2'h0;
            bshown = 2'h0;
            next_line();
            chk_bit(lbi, rows[i][0]);
        end
        $display("test block_table done");
        bot = 10'h3ff;
        c1 = 8'h00;
        c2 = 8'h00;
        pulse_ack(1'b1);
        next_line();
        bact = 2'h1;
        bshown = 2'h1;
        next_line();
        next_line();
        chk_bit(lbi, 1'b0);
        bact = 2'h0;
        bshown = 2'h0;
        next_line();
        chk_bit(lbi, 1'b1);
        next_line();
        chk_bit(lbi, 1'b1);
        pulse_ack(1'b1);
        chk_bit(lbi, 1'b0);
        next_line();
        chk_bit(lbi, 1'b0);
        $display("test block_overlap done");
        fill(1'b0, 4'h5);
        fill(1'b1, 4'ha);
        cen = 2'h3;
        pulse_ack(1'b0);
        frame(4'h5);
        chk_cnt(cnt[0], 640);
        chk_cnt(cnt[1], 640);
        chk_bit(cfi, 1'b1);
        pulse_ack(1'b0);
        chk_bit(cfi, 1'b0);
        vpos[1] = 10'h006;
        frame(4'ha);
        chk_cnt(cnt[0], 704);
        chk_cnt(cnt[1], 640);
        $display("test cursor_fonts done");
        // Doubled scan with a window that leaves the cursor outside.
        cen = 2'h1;
        psel[0] = 4'h4;
        c1 = 8'h23;
        c2 = 8'h10;
        cval = 1'b1;
        co2 = 1'b1;
        frame(4'h4);
        chk_cnt(cnt[0], 1280);
        chk_cnt(cnt[1], 1280);
        chk_cnt(cnt[2], 0);
        chk_cnt(cnt[4], 0);
        $display("test window_biscan done");
        c1 = 8'h00;
        c2 = 8'h00;
        psel[0] = 4'hf;
        frame(4'h5);
        chk_cnt(cnt[0], 640);
        chk_cnt(cnt[2], 640);
        chk_cnt(cnt[3], 0);
        $display("test cursor_priority done");
        // Blank on both sides of a 16-clock gap, outside video blanking.
        cen = 2'h0;
        cval = 1'b0;
        co2 = 1'b0;
        c2 = 8'h30;
        lft = 10'h012;
        rgt = 10'h016;
        frame(4'h0);
        // 53 active lines of 64 clocks: 96 less the gap and sync blank.
        chk_cnt(cnt[4], 3392);
        chk_cnt(cnt[5], 0);
        chk_cnt(cnt[3], 1984);
        chk_cnt(cnt[6], 1984);
        $display("test blank_stripe done");
        end_of_test();
    end
endmodule
`default_nettype wire
